// >>> shared/bridge_defs.svh
// Constants of the local scan port bridge: register map, codes, counts.
// Assumes inclusion by bare name from the package and the design modules.
// How it works
// - Bridge TAP in Test-Logic-Reset performs level 1 reset of everything.
// - Level 1 reset deselects device, parks chains in reset, clears registers.
// - Soft reset drives all local TMS high, resetting local TAPs quickly.
// - Idle ports park in reset (TMS high) or idle/pause states (TMS low).
// - Unparked port waits for bridge TAP to pass its synchronization state.
// - Unpark from reset drives local TMS low on a falling test clock edge.
// - Local TMS follows backplane TMS once bridge TAP reaches the port's sync state.
// - Each port has its own controller; mode bits choose joined ports.
// - Each port joins when its own sync state passes; joined ports keep running.
// - One to eight ports; first mode register ports 0-4, second ports 5-7.
// - Slot address is 5 to 7 bits; codes 3a to 3f are reserved.
// - Up to four dedicated GPIO each way; shared mode reuses TMS, TDO, TDI.
// - Power-up state equals backplane test reset state without any clock.
// - Local test reset low in parked reset state, high otherwise.
// - TDO buffer enables always driven; port enable only in shift states.
// - Port pass-through follows backplane input; backplane follows port input.
// - Pass-through works for single selected port outside parked reset.
// - Parked reset passes 512 test clocks to local clock, then holds low.
`ifndef BRIDGE_DEFS_SVH
`define BRIDGE_DEFS_SVH
`define OFF_CMD        8'h00
`define OFF_CTRL       8'h04
`define OFF_MODE0      8'h08
`define OFF_MODE1      8'h0c
`define OFF_STATUS     8'h10
`define OFF_SLOT       8'h14
`define OFF_GPIO_OUT   8'h18
`define OFF_GPIO_IN    8'h1c
`define OFF_SH_EN      8'h20
`define OFF_SH_VAL     8'h24
`define CMD_W          3
`define MODE_W         8
`define SH_VAL_W       16
`define ST_ACT_LSB     8
`define ST_TLR_LSB     16
`define ST_RSV_BIT     24
`define SH_TDI_LSB     16
`define GPIO_W         4
`define GPIO_OUT_RST   32'h0000_0000
`define TCK_PASS_COUNT 10'h200
`define TCK_CNT_W      10
`define SLOT_RSV_LO    7'h3a
`define SLOT_RSV_HI    7'h3f
`define FIRST_REG_PORTS 5
`endif

// >>> shared/bridge_pkg.sv
// Types shared by the bridge modules: TAP states, port states, commands.
// Assumes bridge_defs.svh is on the include path.
`include "bridge_defs.svh"
package bridge_pkg;
  typedef enum logic [3:0] {
    TAP_TLR    = 4'b0000, TAP_RTI    = 4'b0001, TAP_SEL_DR = 4'b0010,
    TAP_CAP_DR = 4'b0011, TAP_SH_DR  = 4'b0100, TAP_EX1_DR = 4'b0101,
    TAP_PA_DR  = 4'b0110, TAP_EX2_DR = 4'b0111, TAP_UP_DR  = 4'b1000,
    TAP_SEL_IR = 4'b1001, TAP_CAP_IR = 4'b1010, TAP_SH_IR  = 4'b1011,
    TAP_EX1_IR = 4'b1100, TAP_PA_IR  = 4'b1101, TAP_EX2_IR = 4'b1110,
    TAP_UP_IR  = 4'b1111
  } tap_state_e;
  typedef enum logic [2:0] {
    PORT_PARK_TLR = 3'b000, PORT_PARK_RTI = 3'b001,
    PORT_PARK_PDR = 3'b010, PORT_PARK_PIR = 3'b011,
    PORT_SYNC_RTI = 3'b100, PORT_SYNC_PDR = 3'b101,
    PORT_SYNC_PIR = 3'b110, PORT_ACTIVE   = 3'b111
  } port_state_e;
  typedef enum logic [`CMD_W-1:0] {
    CMD_NONE     = 3'b000, CMD_UNPARK   = 3'b001,
    CMD_PARK_TLR = 3'b010, CMD_PARK_RTI = 3'b011,
    CMD_PARK_PDR = 3'b100, CMD_PARK_PIR = 3'b101,
    CMD_SOFT_RST = 3'b110, CMD_SPARE    = 3'b111
  } cmd_e;

  function automatic logic is_shift(input tap_state_e s);
    return (s == TAP_SH_DR) || (s == TAP_SH_IR);
  endfunction : is_shift

  function automatic logic [7:0] port_mask(input logic [7:0] m0,
                                           input logic [7:0] m1);
    return {m1[2:0], m0[4:0]};
  endfunction : port_mask
endpackage : bridge_pkg

// >>> shared/tap_if.sv
// Carrier between the bridge top, its TAP controller and port controllers.
// Assumes the top drives edges, TMS and commands; the TAP drives state.
`timescale 1ns/10ps
interface tap_if;
  import bridge_pkg::*;
  logic       tck_rise;
  logic       tck_fall;
  logic       tms;
  logic       trst;
  tap_state_e state;
  cmd_e       cmd;
  logic       cmd_valid;
  modport tap_side  (input tck_rise, tms, trst, output state);
  modport port_side (input tck_rise, tck_fall, state, cmd, cmd_valid);
endinterface : tap_if

// >>> verilog/bridge_tap.sv
// Bridge TAP controller stepped by sampled backplane clock rising edges.
// Assumes tck_rise is a one-cycle pulse and trst a synchronised level.
`timescale 1ns/10ps
module bridge_tap
  import bridge_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  tap_if.tap_side  bus
);
  typedef struct packed {
    tap_state_e st;
  } tap_s;
  tap_s r;
  tap_s next_r;

  always_comb begin
    next_r = r;
    if (bus.trst) begin
      next_r.st = TAP_TLR;
    end else if (bus.tck_rise) begin
      unique case (r.st)
        TAP_TLR:    next_r.st = bus.tms ? TAP_TLR : TAP_RTI;
        TAP_RTI:    next_r.st = bus.tms ? TAP_SEL_DR : TAP_RTI;
        TAP_SEL_DR: next_r.st = bus.tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: next_r.st = bus.tms ? TAP_EX1_DR : TAP_SH_DR;
        TAP_SH_DR:  next_r.st = bus.tms ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR: next_r.st = bus.tms ? TAP_UP_DR : TAP_PA_DR;
        TAP_PA_DR:  next_r.st = bus.tms ? TAP_EX2_DR : TAP_PA_DR;
        TAP_EX2_DR: next_r.st = bus.tms ? TAP_UP_DR : TAP_SH_DR;
        TAP_UP_DR:  next_r.st = bus.tms ? TAP_SEL_DR : TAP_RTI;
        TAP_SEL_IR: next_r.st = bus.tms ? TAP_TLR : TAP_CAP_IR;
        TAP_CAP_IR: next_r.st = bus.tms ? TAP_EX1_IR : TAP_SH_IR;
        TAP_SH_IR:  next_r.st = bus.tms ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR: next_r.st = bus.tms ? TAP_UP_IR : TAP_PA_IR;
        TAP_PA_IR:  next_r.st = bus.tms ? TAP_EX2_IR : TAP_PA_IR;
        TAP_EX2_IR: next_r.st = bus.tms ? TAP_UP_IR : TAP_SH_IR;
        TAP_UP_IR:  next_r.st = bus.tms ? TAP_SEL_DR : TAP_RTI;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r.st <= TAP_TLR;
    end else begin
      r <= next_r;
    end
  end

  assign bus.state = r.st;
endmodule : bridge_tap

// >>> verilog/port_ctrl.sv
// Controller for one local scan port: park, unpark, sync and clock gating.
// Assumes commands arrive as one-cycle pulses already gated by selection.
`timescale 1ns/10ps
`include "bridge_defs.svh"
module port_ctrl
  import bridge_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  tap_if.port_side   bus,
  input  wire logic  selected,
  output port_state_e state,
  output logic       gated
);
  typedef struct packed {
    port_state_e           st;
    logic [`TCK_CNT_W-1:0] cnt;
  } port_s;
  port_s r;
  port_s next_r;

  always_comb begin
    next_r = r;
    if (bus.state == TAP_TLR) begin
      next_r.st = PORT_PARK_TLR;
    end else if (bus.cmd_valid && bus.cmd == CMD_SOFT_RST) begin
      next_r.st = PORT_PARK_TLR;
    end else if (bus.cmd_valid && selected) begin
      unique case (bus.cmd)
        CMD_UNPARK: begin
          // Ports parked in a pause state resume from that same state.
          if (r.st == PORT_PARK_TLR || r.st == PORT_PARK_RTI)
            next_r.st = PORT_SYNC_RTI;
          else if (r.st == PORT_PARK_PDR)
            next_r.st = PORT_SYNC_PDR;
          else if (r.st == PORT_PARK_PIR)
            next_r.st = PORT_SYNC_PIR;
        end
        CMD_PARK_TLR: begin
          if (r.st[2])
            next_r.st = PORT_PARK_TLR;
        end
        CMD_PARK_RTI: if (r.st == PORT_ACTIVE) next_r.st = PORT_PARK_RTI;
        CMD_PARK_PDR: if (r.st == PORT_ACTIVE) next_r.st = PORT_PARK_PDR;
        CMD_PARK_PIR: if (r.st == PORT_ACTIVE) next_r.st = PORT_PARK_PIR;
        CMD_NONE, CMD_SOFT_RST, CMD_SPARE: next_r.st = r.st;
      endcase
    end else if (bus.tck_fall) begin
      // Each port watches only its own sync state.
      if (r.st == PORT_SYNC_RTI && bus.state == TAP_RTI)
        next_r.st = PORT_ACTIVE;
      else if (r.st == PORT_SYNC_PDR && bus.state == TAP_PA_DR)
        next_r.st = PORT_ACTIVE;
      else if (r.st == PORT_SYNC_PIR && bus.state == TAP_PA_IR)
        next_r.st = PORT_ACTIVE;
    end
    if (r.st != PORT_PARK_TLR) begin
      next_r.cnt = '0;
    end else if (bus.tck_rise && r.cnt != `TCK_PASS_COUNT) begin
      next_r.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r.st  <= PORT_PARK_TLR;
      r.cnt <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign state = r.st;
  assign gated = (r.st == PORT_PARK_TLR) && (r.cnt == `TCK_PASS_COUNT);
endmodule : port_ctrl

// >>> verilog/bridge_top.sv
// Local scan port bridge: pin sampling, APB registers, chain routing.
// Assumes backplane and local pins are asynchronous to sys_clk, with the
// backplane test clock well below a quarter of the system clock.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "bridge_defs.svh"
module bridge_top
  import bridge_pkg::*;
#(
  parameter int NUM_PORTS = 3,
  parameter int SLOT_W    = 7,
  parameter logic [31:0] GPIO_OUT_DEFAULT = `GPIO_OUT_RST
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   tck_b,
  input  wire logic                   tms_b,
  input  wire logic                   tdi_b,
  input  wire logic                   trst_b_n,
  output logic                        tdo_b,
  output logic                        tdo_b_buffer_enable,
  input  wire logic [SLOT_W-1:0]      slot,
  output logic      [NUM_PORTS-1:0]   local_tck,
  output logic      [NUM_PORTS-1:0]   local_tms,
  output logic      [NUM_PORTS-1:0]   local_tdo,
  input  wire logic [NUM_PORTS-1:0]   local_tdi,
  output logic      [NUM_PORTS-1:0]   local_trst_n,
  output logic      [NUM_PORTS-1:0]   tdo_buffer_enable,
  input  wire logic                   pass_in_b,
  output logic                        pass_out_b,
  output logic                        pass_out_b_oe,
  input  wire logic [NUM_PORTS-1:0]   pass_in,
  output logic      [NUM_PORTS-1:0]   pass_out,
  output logic      [NUM_PORTS-1:0]   pass_out_oe,
  input  wire logic [4*NUM_PORTS-1:0] gpio_in,
  output logic      [4*NUM_PORTS-1:0] gpio_out
);
  localparam int N = NUM_PORTS;

  typedef struct packed {
    logic                 tck_m, tck_s, tck_q, fall_d;
    logic                 tms_m, tms_s, tdi_m, tdi_s;
    logic                 trst_m, trst_s, pta_m, pta_s;
    logic [N-1:0]         tdin_m, tdin_s, ptn_m, ptn_s;
    logic [4*N-1:0]       gin_m, gin_s;
    logic [SLOT_W-1:0]    slot_m, slot_s;
    cmd_e                 pend;
    logic                 pend_v;
    cmd_e                 armed;
    logic                 armed_v;
    cmd_e                 cmd;
    logic                 cmd_v;
    logic                 sel;
    logic [`MODE_W-1:0]   mode0, mode1, shen;
    logic [`SH_VAL_W-1:0] shval;
    logic [31:0]          gout;
    logic [31:0]          prdata;
    logic                 pready, pslverr;
    logic [N-1:0]         tck_n, tms_n, tdo_n, trst_n, tdo_en;
    logic [N-1:0]         pty, pty_oe;
    logic                 tdo_b, tdo_b_en, ptyb, ptyb_oe;
  } top_s;
  top_s r;
  top_s next_r;

  tap_if       bus();
  port_state_e pst [N];
  logic [N-1:0] gated;
  logic [7:0]   sel_mask;

  assign sel_mask = port_mask(r.mode0, r.mode1);

  // Edges of the sampled test clock, seen in the same cycle the second flop changes.
  assign bus.tck_rise  = r.tck_s & ~r.tck_q;
  assign bus.tck_fall  = ~r.tck_s & r.tck_q;
  assign bus.tms       = r.tms_s;
  assign bus.trst      = ~r.trst_s;
  assign bus.cmd       = r.cmd;
  assign bus.cmd_valid = r.cmd_v;

  bridge_tap u_tap (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bus     (bus)
  );

  // One controller per local port.
  for (genvar g = 0; g < N; g++) begin : g_port
    port_ctrl u_port (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .bus      (bus),
      .selected (sel_mask[g]),
      .state    (pst[g]),
      .gated    (gated[g])
    );
  end

  // Offsets that answer; any other address ends in an error.
  function automatic logic addr_ok(input logic [7:0] a);
    return a == `OFF_CMD || a == `OFF_CTRL || a == `OFF_MODE0 ||
           a == `OFF_MODE1 || a == `OFF_STATUS || a == `OFF_SLOT ||
           a == `OFF_GPIO_OUT || a == `OFF_GPIO_IN || a == `OFF_SH_EN ||
           a == `OFF_SH_VAL;
  endfunction : addr_ok

  always_comb begin
    logic [7:0]   act_v;
    logic [7:0]   tlr_v;
    logic [7:0]   tdi_v;
    logic [7:0]   mask;
    logic [N-1:0] pt_en;
    logic         data;
    logic         single;
    logic         pt_sel;
    logic [6:0]   slot7;
    logic         wr;
    act_v  = '0;
    tlr_v  = '0;
    tdi_v  = '0;
    pt_en  = '0;
    pt_sel = 1'b0;
    data   = r.tdi_s;
    mask   = port_mask(r.mode0, r.mode1);
    single = $onehot(mask[N-1:0]);
    slot7  = 7'(r.slot_s);
    wr     = psel && penable && pwrite && r.pready;
    next_r = r;
    // Two-flop capture of every asynchronous pin.
    next_r.tck_m  = tck_b;
    next_r.tck_s  = r.tck_m;
    next_r.tck_q  = r.tck_s;
    next_r.fall_d = bus.tck_fall;
    next_r.tms_m  = tms_b;
    next_r.tms_s  = r.tms_m;
    next_r.tdi_m  = tdi_b;
    next_r.tdi_s  = r.tdi_m;
    next_r.trst_m = trst_b_n;
    next_r.trst_s = r.trst_m;
    next_r.pta_m  = pass_in_b;
    next_r.pta_s  = r.pta_m;
    next_r.tdin_m = local_tdi;
    next_r.tdin_s = r.tdin_m;
    next_r.ptn_m  = pass_in;
    next_r.ptn_s  = r.ptn_m;
    next_r.gin_m  = gpio_in;
    next_r.gin_s  = r.gin_m;
    // Slot straps are sampled like any pin, though they change only at power-up.
    next_r.slot_m = slot;
    next_r.slot_s = r.slot_m;
    next_r.pready = 1'b1;
    next_r.cmd_v  = 1'b0;
    // Commands load as the bridge TAP leaves Update-IR.
    // Without selection the pending command is dropped.
    if (bus.tck_rise && bus.state == TAP_UP_IR && r.pend_v) begin
      next_r.pend_v = 1'b0;
      if (r.sel && (r.pend == CMD_PARK_RTI || r.pend == CMD_PARK_PDR ||
                    r.pend == CMD_PARK_PIR)) begin
        next_r.armed   = r.pend;
        next_r.armed_v = 1'b1;
      end else if (r.sel) begin
        next_r.cmd   = r.pend;
        next_r.cmd_v = 1'b1;
      end
    end
    // Parking in idle or pause waits until the bridge TAP is there too.
    // It fires as soon as the TAP has entered that state, so the port stops
    // following backplane TMS before the next local clock rise.
    if (r.armed_v &&
        ((r.armed == CMD_PARK_RTI && bus.state == TAP_RTI) ||
         (r.armed == CMD_PARK_PDR && bus.state == TAP_PA_DR) ||
         (r.armed == CMD_PARK_PIR && bus.state == TAP_PA_IR))) begin
      next_r.armed_v = 1'b0;
      next_r.cmd     = r.armed;
      next_r.cmd_v   = 1'b1;
    end
    if (wr) begin
      unique case (paddr)
        `OFF_CMD: begin
          next_r.pend   = cmd_e'(pwdata[`CMD_W-1:0]);
          next_r.pend_v = 1'b1;
        end
        `OFF_CTRL:     next_r.sel   = pwdata[0];
        `OFF_MODE0:    next_r.mode0 = pwdata[`MODE_W-1:0];
        `OFF_MODE1:    next_r.mode1 = pwdata[`MODE_W-1:0];
        `OFF_GPIO_OUT: next_r.gout  = pwdata;
        `OFF_SH_EN:    next_r.shen  = pwdata[`MODE_W-1:0];
        `OFF_SH_VAL:   next_r.shval = pwdata[`SH_VAL_W-1:0];
        default:       next_r.sel   = r.sel;
      endcase
    end
    // Bridge TAP in Test-Logic-Reset holds the device in its reset state.
    // Clearing wins over a register write in the same cycle.
    if (bus.state == TAP_TLR) begin
      next_r.sel     = 1'b0;
      next_r.pend_v  = 1'b0;
      next_r.armed_v = 1'b0;
      next_r.cmd_v   = 1'b0;
      next_r.mode0   = '0;
      next_r.mode1   = '0;
      next_r.shen    = '0;
      next_r.shval   = '0;
      next_r.gout    = GPIO_OUT_DEFAULT;
    end
    // Port outputs and the active chain from backplane TDI to TDO.
    for (int i = 0; i < N; i++) begin
      act_v[i] = pst[i] == PORT_ACTIVE;
      tlr_v[i] = pst[i] == PORT_PARK_TLR;
      tdi_v[i] = r.tdin_s[i];
      // The local clock copies the sampled test clock until its count ends.
      next_r.tck_n[i]  = gated[i] ? 1'b0 : r.tck_s;
      next_r.trst_n[i] = !tlr_v[i];
      next_r.tdo_en[i] = act_v[i] && is_shift(bus.state);
      if (r.shen[i]) begin
        next_r.tms_n[i] = r.shval[2*i];
        next_r.tdo_n[i] = r.shval[2*i+1];
      end else begin
        // A port parked in reset holds TMS high at once, clock or no clock.
        if (act_v[i])
          next_r.tms_n[i] = r.tms_s;
        else if (tlr_v[i])
          next_r.tms_n[i] = 1'b1;
        else if (r.fall_d)
          next_r.tms_n[i] = 1'b0;
        // Inactive ports drop out of the chain; data skips past them.
        if (act_v[i]) begin
          if (r.fall_d)
            next_r.tdo_n[i] = data;
          data = r.tdin_s[i];
        end
      end
      pt_en[i] = single && mask[i] && !tlr_v[i];
      next_r.pty[i]    = r.pta_s;
      next_r.pty_oe[i] = pt_en[i];
      pt_sel = pt_sel | (pt_en[i] & r.ptn_s[i]);
    end
    next_r.ptyb    = pt_sel;
    next_r.ptyb_oe = |pt_en;
    if (r.fall_d)
      next_r.tdo_b = data;
    next_r.tdo_b_en = is_shift(bus.state);
    // APB read data and error are formed in the setup cycle.
    // They stand through the access phase, which pready never stretches.
    if (psel && !penable) begin
      next_r.pslverr = !addr_ok(paddr);
      unique case (paddr)
        `OFF_CMD:      next_r.prdata = {28'h0, r.pend_v, r.pend};
        `OFF_CTRL:     next_r.prdata = {31'h0, r.sel};
        `OFF_MODE0:    next_r.prdata = {24'h0, r.mode0};
        `OFF_MODE1:    next_r.prdata = {24'h0, r.mode1};
        `OFF_STATUS: begin
          next_r.prdata = {28'h0, bus.state};
          next_r.prdata[`ST_ACT_LSB+:8] = act_v;
          next_r.prdata[`ST_TLR_LSB+:8] = tlr_v;
          next_r.prdata[`ST_RSV_BIT] = slot7 >= `SLOT_RSV_LO &&
                                       slot7 <= `SLOT_RSV_HI;
        end
        `OFF_SLOT:     next_r.prdata = {25'h0, slot7};
        `OFF_GPIO_OUT: next_r.prdata = r.gout;
        `OFF_GPIO_IN:  next_r.prdata = 32'(r.gin_s);
        `OFF_SH_EN:    next_r.prdata = {24'h0, r.shen};
        `OFF_SH_VAL: begin
          next_r.prdata = {16'h0, r.shval};
          next_r.prdata[`SH_TDI_LSB+:8] = tdi_v;
        end
        default:       next_r.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r      <= '0;
      r.gout <= GPIO_OUT_DEFAULT;
      r.tms_n <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata              = r.prdata;
  assign pready              = r.pready;
  assign pslverr             = r.pslverr;
  assign tdo_b               = r.tdo_b;
  assign tdo_b_buffer_enable = r.tdo_b_en;
  assign local_tck           = r.tck_n;
  assign local_tms           = r.tms_n;
  assign local_tdo           = r.tdo_n;
  assign local_trst_n        = r.trst_n;
  assign tdo_buffer_enable   = r.tdo_en;
  assign pass_out_b          = r.ptyb;
  assign pass_out_b_oe       = r.ptyb_oe;
  assign pass_out            = r.pty;
  assign pass_out_oe         = r.pty_oe;
  assign gpio_out            = r.gout[4*N-1:0];
endmodule : bridge_top

// >>> tb/bridge_top_asserts.sv
// Checker for the bridge top: parking, enables, pass-through, APB errors.
// Assumes it is bound into bridge_top and sees only its ports.
`timescale 1ns/10ps
module bridge_top_asserts #(
  parameter int NUM_PORTS = 3
) (
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [7:0]           paddr,
  input wire logic                 pslverr,
  input wire logic                 tms_b,
  input wire logic                 trst_b_n,
  input wire logic                 pass_in_b,
  input wire logic                 tdo_b_buffer_enable,
  input wire logic [NUM_PORTS-1:0] local_tms,
  input wire logic [NUM_PORTS-1:0] local_trst_n,
  input wire logic [NUM_PORTS-1:0] tdo_buffer_enable,
  input wire logic [NUM_PORTS-1:0] pass_out,
  input wire logic [NUM_PORTS-1:0] pass_out_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_park_tms_high: assert property ((~local_trst_n & ~local_tms) == '0)
    else $error("local tms low while parked in reset");
  a_enable_unparked: assert property ((tdo_buffer_enable & ~local_trst_n) == '0)
    else $error("port tdo enabled while parked in reset");
  a_enable_shift_b: assert property (|tdo_buffer_enable |-> tdo_b_buffer_enable)
    else $error("port enable outside a shift state");
  a_pass_oe_park: assert property ((pass_out_oe & ~local_trst_n) == '0)
    else $error("pass-through enabled while parked in reset");
  a_trst_parks_all: assert property (!trst_b_n [*6] |=> local_trst_n == '0 && &local_tms)
    else $error("test reset did not park all ports");
  a_pass_follows: assert property ($stable(pass_in_b) [*4] ##0 pass_out_oe[0] |-> pass_out[0] == pass_in_b)
    else $error("pass-through output does not follow input");
  a_tms_follows: assert property ($stable(tms_b) [*4] ##0 tdo_buffer_enable[0] |-> local_tms[0] == tms_b)
    else $error("active port tms does not follow backplane");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access without error");
  c_all_active: cover property (&tdo_buffer_enable);
  c_pass_on: cover property (|pass_out_oe);
  c_trst_held: cover property (!trst_b_n ##1 !trst_b_n);
endmodule : bridge_top_asserts
bind bridge_top bridge_top_asserts #(.NUM_PORTS(NUM_PORTS)) chk (.sys_clk,
  .rst_n, .psel, .penable, .paddr, .pslverr, .tms_b, .trst_b_n, .pass_in_b,
  .tdo_b_buffer_enable, .local_tms, .local_trst_n, .tdo_buffer_enable,
  .pass_out, .pass_out_oe);

// >>> tb/scan_far_side.sv
// Far side: backplane test master and one-bit local scan chains.
// Assumes sys_clk paces the master and three local ports.
`timescale 1ns/10ps
module scan_far_side (
  input  wire logic       sys_clk,
  input  wire logic [2:0] local_tck,
  input  wire logic [2:0] local_tdo,
  input  wire logic [2:0] local_trst_n,
  output logic            tck_b,
  output logic            tms_b,
  output logic            tdi_b,
  output logic            trst_b_n,
  output logic      [2:0] local_tdi
);
  logic [2:0] chain;
  initial begin
    {tck_b, tms_b, tdi_b, trst_b_n} = 4'h1;
    chain = 3'h0;
  end
  for (genvar i = 0; i < 3; i++) begin : g_chain
    always @(posedge local_tck[i]) chain[i] <= local_tdo[i];
  end
  // A chain parked in reset is released, so its pull-up shows high.
  assign local_tdi = chain | ~local_trst_n;
  // The test clock stands still low between steps.
  task automatic step(input logic t, input logic d);
    @(posedge sys_clk);
    tms_b <= t;
    tdi_b <= d;
    repeat (3) @(posedge sys_clk);
    tck_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tck_b <= 1'b0;
  endtask : step
  task automatic go(input logic [15:0] b, input int n, input logic d);
    for (int i = 0; i < n; i++) step(b[i], d);
  endtask : go
  task automatic set_trst(input logic v);
    @(posedge sys_clk);
    trst_b_n <= v;
  endtask : set_trst
endmodule : scan_far_side

// >>> tb/local_scan_port_park_sync_test.sv
// Bench for the bridge: unpark rows, sync, resets, gating, APB errors.
// Assumes scan_far_side and the bound checker are compiled before it.
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module local_scan_port_park_sync_test;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic tck_b, tms_b, tdi_b, trst_b_n, tdo_b, tdo_b_buffer_enable;
  logic pass_in_b, pass_out_b, pass_out_b_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] slot;
  logic [2:0] local_tck, local_tms, local_tdo, local_tdi, local_trst_n;
  logic [2:0] tdo_buffer_enable, pass_in, pass_out, pass_out_oe;
  logic [11:0] gpio_in, gpio_out;
  int err_total, compares, pulses;
  // Each row: port mask, then expected pass-through enables.
  localparam logic [5:0] ROWS [7] = '{6'h09, 6'h12, 6'h24, 6'h18,
                                      6'h28, 6'h30, 6'h38};
  bridge_top DUT (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tck_b, .tms_b, .tdi_b,
    .trst_b_n, .tdo_b, .tdo_b_buffer_enable, .slot, .local_tck,
    .local_tms, .local_tdo, .local_tdi, .local_trst_n, .tdo_buffer_enable,
    .pass_in_b, .pass_out_b, .pass_out_b_oe, .pass_in, .pass_out,
    .pass_out_oe, .gpio_in, .gpio_out);
  scan_far_side m (.sys_clk, .local_tck, .local_tdo, .local_trst_n,
    .tck_b, .tms_b, .tdi_b, .trst_b_n, .local_tdi);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge local_tck[0]) pulses++;
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic cmd(input logic [2:0] p, input logic [2:0] c);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h08, {29'h0, p});
    apb(1'b1, 8'h00, {29'h0, c});
    m.go(16'h33, 7, 1'b0);
  endtask : cmd
  task automatic wait5;
    repeat (5) @(posedge sys_clk);
  endtask : wait5
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {err_total, compares, pulses} = '0;
    {slot, gpio_in, pass_in_b, pass_in} = {7'h05, 12'h0, 1'b1, 3'h5};
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 7; r++) begin
      m.go(16'h1f, 6, 1'b0);
      wait5();
      `CHK("trst_n", 3'h0, local_trst_n)
      cmd(ROWS[r][5:3], 3'h1);
      m.go(16'h1, 3, ~r[0]);
      m.go(16'h0, 5, ~r[0]);
      wait5();
      `CHK("enable", ROWS[r][5:3], tdo_buffer_enable)
      `CHK("trst_n", ROWS[r][5:3], local_trst_n)
      `CHK("b enable", 1'b1, tdo_b_buffer_enable)
      `CHK("tdo_b", ~r[0], tdo_b)
      `CHK("pass oe", ROWS[r][2:0], pass_out_oe)
      `CHK("pass b oe", ROWS[r][2:0] != 3'h0, pass_out_b_oe)
      if (ROWS[r][2:0] != 3'h0) begin
        `CHK("pass out", ROWS[r][2:0], pass_out & pass_out_oe)
        `CHK("pass b", |(pass_in & ROWS[r][2:0]), pass_out_b)
      end
      $display("row %0d done", r);
    end
    m.go(16'h3, 3, 1'b0);
    cmd(3'h0, 3'h6);
    apb(1'b1, 8'h18, 32'ha5c);
    wait5();
    `CHK("soft tms", 3'h7, local_tms)
    `CHK("gpio", 12'ha5c, gpio_out)
    `CHK("soft trst", 3'h0, local_trst_n)
    cmd(3'h4, 3'h1);
    cmd(3'h4, 3'h4);
    m.go(16'h09, 5, 1'b0);
    wait5();
    `CHK("park pdr", 2'h2, {local_trst_n[2], local_tms[2]})
    m.go(16'h3, 3, 1'b0);
    cmd(3'h7, 3'h1);
    m.go(16'h1, 3, 1'b0);
    wait5();
    `CHK("early", 3'h3, tdo_buffer_enable)
    m.go(16'h5, 4, 1'b0);
    wait5();
    `CHK("late", 3'h7, tdo_buffer_enable)
    $display("sync test done");
    m.go(16'h3, 3, 1'b0);
    cmd(3'h2, 3'h2);
    wait5();
    `CHK("park one", 3'h5, local_trst_n)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 33'h100000000, {er, rd})
    m.set_trst(1'b0);
    repeat (10) @(posedge sys_clk);
    `CHK("trst park", 6'h38, {local_tms, local_trst_n})
    apb(1'b0, 8'h08, 32'h0);
    `CHK("mode init", 32'h0, rd)
    `CHK("gpio init", 12'h0, gpio_out)
    m.set_trst(1'b1);
    wait5();
    pulses = 0;
    for (int i = 0; i < 600; i++) m.step(1'b1, 1'b0);
    wait5();
    `CHK("pulses", 512, pulses)
    `CHK("tck low", 3'h0, local_tck)
    $display("reset and gating done");
    results();
  end
  initial begin
    #750000;
    err_total++;
    results();
  end
endmodule : local_scan_port_park_sync_test
